// File: hdl/timer_pair.sv
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ns
// Function
// - 16-bit counter, clock or events, direction, period
// - channels capture or compare, never both
// - two counters cascade into 32 bits
// - clock is prescaled clock or event channel
// - events steer direction, capture and restart
// - four channels first timer, two second
// - split gives two 8-bit, eight PWMs
// - split events only from low byte
// - split halves share clock, separate settings
// - split halves only count down, flag underflow
// - split waveform is single-slope PWM only
// - normal mode returns to unsplit 16-bit
// - extension splits outputs into complementary pairs
// - dead time per edge, double buffered
// - four dead-time units, optional counter halt
// - extension outputs replace overridden pins only
// - buffered pattern or channel A distribution
// - pattern generator bypasses dead-time path
// - selected event fault disables extension outputs
// - extension only on four-channel timer
// - fine resolution 4x or 8x, with extension
module timer_pair (
  input  wire logic                          clk,       // Quad-rate clock
  input  wire logic                          arst_n,    // Async reset
  input  wire logic                          wb_cyc_i,  // Bus cycle
  input  wire logic                          wb_stb_i,  // Bus strobe
  input  wire logic                          wb_we_i,   // Write
  input  wire logic [timer_pkg::ADR_W-1:0]   wb_adr_i,  // Byte address
  input  wire logic [3:0]                    wb_sel_i,  // Byte enables
  input  wire logic [31:0]                   wb_dat_i,  // Write data
  output logic [31:0]                        wb_dat_o,  // Read data
  output logic                               wb_ack_o,  // Ack
  input  wire logic [3:0]                    evt_in,    // Event channels
  output logic [7:0]                         port_out,  // Four-channel port
  output logic [1:0]                         t1_out,    // Two-channel pins
  output logic [7:0]                         evt_out    // Event pulses
);
  import timer_pkg::*;

  logic [31:0] ctrl_r [2];
  logic [31:0] ctrl_nxt [2];
  logic [15:0] per_r [2];
  logic [15:0] per_nxt [2];
  logic [15:0] perb_r [2];
  logic [15:0] perb_nxt [2];
  logic [15:0] cnt_r [2];
  logic [15:0] cnt_nxt [2];
  logic [15:0] cc_r [6];
  logic [15:0] cc_nxt [6];
  logic [15:0] ccb_r [6];
  logic [15:0] ccb_nxt [6];
  logic [5:0]  wg_r, wg_nxt;
  logic [1:0]  dsl_r, dsl_nxt;
  logic [15:0] dead_r, dead_nxt, deadb_r, deadb_nxt;
  logic [7:0]  pat_r, pat_nxt, patb_r, patb_nxt, ovr_r, ovr_nxt;
  logic [3:0]  fmask_r, fmask_nxt;
  logic [9:0]  stat_r, stat_nxt, pre_r, pre_nxt;
  logic [2:0]  fine_r, fine_nxt, fmax;
  logic [7:0]  port_r, port_nxt, evo_r, evo_nxt;
  logic [1:0]  t1o_r, t1o_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [3:0]  ls, hs, dt_busy;
  logic [1:0]  hr;
  logic        pclk, tk, dn, ov, fault_now, wr;
  logic [31:0] c;
  logic [15:0] pos;
  logic [16:0] st;
  logic [7:0]  lo, hi, norm, wexv, dead_time_unit;
  logic [2:0]  base;
  logic [1:0]  n;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  // Clock select: off, seven prescale taps, or an event channel
  function automatic logic tick_of(input logic [3:0] s, input logic [9:0] p,
                                   input logic e, input logic [3:0] ev);
    logic [9:0] m;
    m = 10'h000;
    unique case (s[2:0])
      3'h2: m = 10'h001;
      3'h3: m = 10'h003;
      3'h4: m = 10'h007;
      3'h5: m = 10'h03F;
      3'h6: m = 10'h0FF;
      3'h7: m = 10'h3FF;
      default: m = 10'h000;
    endcase
    if (s[3]) begin
      tick_of = ev[s[1:0]];
    end else begin
      tick_of = e && (s[2:0] != 3'h0) && ((p & m) == m);
    end
  endfunction

  // Single-slope step; >= keeps a lowered period from running away
  function automatic logic [16:0] step(input logic [15:0] v, pr, input logic d);
    if (d) begin
      step = (v == 16'h0000) ? {1'b1, pr} : {1'b0, v - 16'h0001};
    end else begin
      step = (v >= pr) ? {1'b1, 16'h0000} : {1'b0, v + 16'h0001};
    end
  endfunction

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign hr = ctrl_r[0][CT_HR +: 2];
  assign fault_now = |(fmask_r & evt_in);

  // Dead-time units, one per channel of timer zero
  // four dead-time units
  for (genvar i = 0; i < 4; i++) begin : g_dt
    logic [7:0] dc_r, dc_nxt;
    logic       wp_r, wp_nxt, ls_r, ls_nxt, hs_r, hs_nxt;
    // on each edge the side turning on waits its own delay
    always_comb begin
      wp_nxt = wg_r[i];
      dc_nxt = (dc_r != 8'h00) ? dc_r - 8'h01 : dc_r;
      if (wg_r[i] != wp_r) begin
        dc_nxt = wg_r[i] ? dead_r[7:0] : dead_r[15:8];
      end
      ls_nxt = wg_r[i] & (dc_nxt == 8'h00);
      hs_nxt = ~wg_r[i] & (dc_nxt == 8'h00);
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        dc_r <= 8'h00;
        wp_r <= 1'b0;
        ls_r <= 1'b0;
        hs_r <= 1'b0;
      end else begin
        dc_r <= dc_nxt;
        wp_r <= wp_nxt;
        ls_r <= ls_nxt;
        hs_r <= hs_nxt;
      end
    end
    assign ls[i] = ls_r;
    assign hs[i] = hs_r;
    assign dt_busy[i] = (dc_r != 8'h00);
  end

  // Counters, channels, buffers, status and bus
  always_comb begin
    ctrl_nxt = ctrl_r;
    per_nxt = per_r;
    perb_nxt = perb_r;
    cnt_nxt = cnt_r;
    cc_nxt = cc_r;
    ccb_nxt = ccb_r;
    wg_nxt = wg_r;
    dsl_nxt = dsl_r;
    dead_nxt = dead_r;
    deadb_nxt = deadb_r;
    pat_nxt = pat_r;
    patb_nxt = patb_r;
    ovr_nxt = ovr_r;
    fmask_nxt = fmask_r;
    stat_nxt = stat_r;
    // Write one to clear first, so an event in the same cycle sets again
    if (wr && ({wb_adr_i[ADR_W-1:2], 2'b00} == A_STAT)) begin
      stat_nxt = stat_r & ~10'(merge(32'h0, wb_dat_i, wb_sel_i));
    end
    evo_nxt = 8'h00;
    tk = 1'b0;
    dn = 1'b0;
    ov = 1'b0;
    c = 32'h0;
    pos = 16'h0;
    st = 17'h0;
    lo = 8'h00;
    hi = 8'h00;
    base = 3'h0;
    n = 2'h0;
    // with fine resolution on, counter ticks every 4 or 8 fast cycles, sub-steps refine compare
    // relies on clk being exactly four times the peripheral rate
    fmax = (hr == HR_8X) ? 3'h7 : 3'h3;
    pclk = (hr == HR_OFF) || (fine_r == fmax);
    fine_nxt = pclk ? 3'h0 : fine_r + 3'h1;
    pre_nxt = pclk ? pre_r + 10'h001 : pre_r;
    for (int t = 0; t < 2; t++) begin
      c = ctrl_r[t];
      base = (t == 0) ? 3'h0 : 3'h4;
      // clock from prescaler tap or event channel
      tk = tick_of(c[CT_CLK +: 4], pre_r, pclk, evt_in);
      // upper counter advances on lower overflow
      if (t == 1 && c[CT_CASC]) begin
        tk = evo_nxt[0];
      end
      // optional halt while dead time runs
      if (t == 0 && c[CT_HALT] && c[CT_WEX] && |dt_busy) begin
        tk = 1'b0;
      end
      dn = c[CT_DN] ^ (c[CT_DEV] & evt_in[c[CT_DCH +: 2]]);
      ov = 1'b0;
      // split only on the four-channel timer
      if (t == 0 && c[CT_SPLIT]) begin
        lo = cnt_r[0][7:0];
        hi = cnt_r[0][15:8];
        if (tk) begin
          // shared tick, separate period per half
          // both halves count down and flag underflow
          cnt_nxt[0][7:0] = (lo == 8'h00) ? per_r[0][7:0] : lo - 8'h01;
          cnt_nxt[0][15:8] = (hi == 8'h00) ? per_r[0][15:8] : hi - 8'h01;
          ov = (lo == 8'h00);
          if (hi == 8'h00) begin
            stat_nxt[ST_UFHI] = 1'b1;
          end
          // only the low byte raises compare events
          for (int i = 0; i < 4; i++) begin
            evo_nxt[1 + i] = (lo == cc_r[i][7:0]);
          end
        end
      end else if (tk) begin
        // 16-bit count up or down to the period
        if (c[CT_WG +: 2] == WG_DS && !c[CT_CAP]) begin
          if (!dsl_r[t]) begin
            dsl_nxt[t] = (cnt_r[t] >= per_r[t]);
            cnt_nxt[t] = dsl_nxt[t] ? cnt_r[t] - 16'h0001 : cnt_r[t] + 16'h0001;
          end else begin
            ov = (cnt_r[t] == 16'h0000);
            dsl_nxt[t] = ~ov;
            cnt_nxt[t] = ov ? 16'h0001 : cnt_r[t] - 16'h0001;
          end
        end else begin
          st = step(cnt_r[t], per_r[t], dn);
          ov = st[16];
          cnt_nxt[t] = st[15:0];
        end
        if (!c[CT_CAP]) begin
          for (int i = 0; i < 4; i++) begin
            // third and fourth channel only on timer zero
            if (t == 0 || i < 2) begin
              evo_nxt[base + 3'h1 + 3'(t) + 3'(i)] = (cnt_r[t] == cc_r[base + 3'(i)]);
            end
          end
        end
      end
      // Timer one's overflow sits at bit five, its channels above it
      evo_nxt[base + 3'(t)] = ov;
      if (c[CT_RST] && evt_in[c[CT_RCH +: 2]]) begin
        cnt_nxt[t] = 16'h0000;
      end
      if (ov) begin
        stat_nxt[(t == 0) ? ST_OVF0 : ST_OVF1] = 1'b1;
        per_nxt[t] = perb_r[t];
        if (t == 0) begin
          // dead-time values take effect at update
          dead_nxt = deadb_r;
          // pattern buffer takes effect at update
          pat_nxt = patb_r;
        end
      end
      // fine position joins counter and sub-step
      unique case (hr)
        2'h1: pos = {cnt_r[t][13:0], fine_r[1:0]};
        2'h2: pos = {cnt_r[t][12:0], fine_r};
        default: pos = cnt_r[t];
      endcase
      for (int i = 0; i < 4; i++) begin
        if (t == 0 || i < 2) begin
          n = 2'(i);
          if (c[CT_CAP]) begin
            // each timer's channel i captures its count on event channel CT_CCH plus i
            if (evt_in[c[CT_CCH +: 2] + n]) begin
              cc_nxt[base + 3'(i)] = cnt_r[t];
              evo_nxt[base + 3'h1 + 3'(t) + 3'(i)] = 1'b1;
            end
            wg_nxt[base + 3'(i)] = 1'b0;
          end else begin
            if (ov) begin
              cc_nxt[base + 3'(i)] = ccb_r[base + 3'(i)];
            end
            if (c[CT_WG +: 2] == WG_FREQ) begin
              wg_nxt[base + 3'(i)] = wg_r[base + 3'(i)] ^ evo_nxt[base + 3'h1 + 3'(t) + 3'(i)];
            end else begin
              wg_nxt[base + 3'(i)] = (cc_r[base + 3'(i)] > pos);
            end
          end
        end
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (evo_nxt[i]) begin
        stat_nxt[i] = 1'b1;
      end
    end
    // fault event latches a sticky flag
    if (fault_now) begin
      stat_nxt[ST_FAULT] = 1'b1;
    end
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    if (wr) begin
      unique case ({wb_adr_i[ADR_W-1:2], 2'b00})
        A_CTRL0: ctrl_nxt[0] = merge(ctrl_r[0], wb_dat_i, wb_sel_i);
        A_CTRL1: ctrl_nxt[1] = merge(ctrl_r[1], wb_dat_i, wb_sel_i) & 32'hFFFF_F0BF;
        A_PER0:  perb_nxt[0] = 16'(merge({16'h0, perb_r[0]}, wb_dat_i, wb_sel_i));
        A_PER1:  perb_nxt[1] = 16'(merge({16'h0, perb_r[1]}, wb_dat_i, wb_sel_i));
        A_CNT0:  cnt_nxt[0] = 16'(merge({16'h0, cnt_r[0]}, wb_dat_i, wb_sel_i));
        A_CNT1:  cnt_nxt[1] = 16'(merge({16'h0, cnt_r[1]}, wb_dat_i, wb_sel_i));
        A_CC0:        ccb_nxt[0] = 16'(merge({16'h0, ccb_r[0]}, wb_dat_i, wb_sel_i));
        A_CC0 + 8'h4: ccb_nxt[1] = 16'(merge({16'h0, ccb_r[1]}, wb_dat_i, wb_sel_i));
        A_CC0 + 8'h8: ccb_nxt[2] = 16'(merge({16'h0, ccb_r[2]}, wb_dat_i, wb_sel_i));
        A_CC0 + 8'hC: ccb_nxt[3] = 16'(merge({16'h0, ccb_r[3]}, wb_dat_i, wb_sel_i));
        A_CC1:        ccb_nxt[4] = 16'(merge({16'h0, ccb_r[4]}, wb_dat_i, wb_sel_i));
        A_CC1 + 8'h4: ccb_nxt[5] = 16'(merge({16'h0, ccb_r[5]}, wb_dat_i, wb_sel_i));
        A_DEAD:  deadb_nxt = 16'(merge({16'h0, deadb_r}, wb_dat_i, wb_sel_i));
        A_PAT:   patb_nxt = wb_sel_i[0] ? wb_dat_i[7:0] : patb_r;
        A_OVR: begin
          ovr_nxt = wb_sel_i[0] ? wb_dat_i[7:0] : ovr_r;
          fmask_nxt = wb_sel_i[1] ? wb_dat_i[OV_FM +: 4] : fmask_r;
        end
        default: ;
      endcase
    end
    // Registers read back active values; unmapped reads zero
    unique case ({wb_adr_i[ADR_W-1:2], 2'b00})
      A_CTRL0: dat_nxt = ctrl_r[0];
      A_CTRL1: dat_nxt = ctrl_r[1];
      A_PER0:  dat_nxt = {16'h0, per_r[0]};
      A_PER1:  dat_nxt = {16'h0, per_r[1]};
      A_CNT0:  dat_nxt = {16'h0, cnt_r[0]};
      A_CNT1:  dat_nxt = {16'h0, cnt_r[1]};
      A_CC0:        dat_nxt = {16'h0, cc_r[0]};
      A_CC0 + 8'h4: dat_nxt = {16'h0, cc_r[1]};
      A_CC0 + 8'h8: dat_nxt = {16'h0, cc_r[2]};
      A_CC0 + 8'hC: dat_nxt = {16'h0, cc_r[3]};
      A_CC1:        dat_nxt = {16'h0, cc_r[4]};
      A_CC1 + 8'h4: dat_nxt = {16'h0, cc_r[5]};
      A_DEAD:  dat_nxt = {16'h0, dead_r};
      A_PAT:   dat_nxt = {24'h0, pat_r};
      A_OVR:   dat_nxt = {20'h0, fmask_r, ovr_r};
      A_STAT:  dat_nxt = {22'h0, stat_r};
      default: dat_nxt = 32'h0;
    endcase
  end

  // Pin mixing; fault path is combinational so the pins drop next edge
  always_comb begin
    norm = {4'h0, wg_r[3:0]};
    // split halves give single-slope PWM only
    if (ctrl_r[0][CT_SPLIT]) begin
      for (int i = 0; i < 4; i++) begin
        norm[i] = (cc_r[i][7:0] > cnt_r[0][7:0]);
        norm[4 + i] = (cc_r[i][15:8] > cnt_r[0][15:8]);
      end
    end
    // each generator output becomes a complementary pair
    for (int i = 0; i < 4; i++) begin
      dead_time_unit[2 * i] = ls[i];
      dead_time_unit[2 * i + 1] = hs[i];
    end
    // pattern, or channel A spread over the port
    // pattern mode bypasses the dead-time path
    if (ctrl_r[0][CT_PAT]) begin
      wexv = ctrl_r[0][CT_DIST] ? {8{wg_r[0]}} & pat_r : pat_r;
    end else begin
      wexv = dead_time_unit;
    end
    if (stat_r[ST_FAULT] | fault_now) begin
      wexv = 8'h00;
    end
    // extension serves only the four-channel port, unsplit
    // clearing split restores the plain 16-bit outputs
    if (ctrl_r[0][CT_WEX] && !ctrl_r[0][CT_SPLIT]) begin
      // override mask picks which pins are replaced
      port_nxt = (ovr_r & wexv) | (~ovr_r & norm);
    end else begin
      port_nxt = norm;
    end
    t1o_nxt = wg_r[5:4];
  end

  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= '{CTRL_RST, CTRL_RST};
      per_r <= '{PER_RST, PER_RST};
      perb_r <= '{PER_RST, PER_RST};
      cnt_r <= '{16'h0000, 16'h0000};
      cc_r <= '{default: 16'h0000};
      ccb_r <= '{default: 16'h0000};
      wg_r <= 6'h00;
      dsl_r <= 2'h0;
      dead_r <= DEAD_RST;
      deadb_r <= DEAD_RST;
      pat_r <= PAT_RST;
      patb_r <= PAT_RST;
      ovr_r <= 8'h00;
      fmask_r <= 4'h0;
      stat_r <= 10'h000;
      pre_r <= 10'h000;
      fine_r <= 3'h0;
      port_r <= 8'h00;
      evo_r <= 8'h00;
      t1o_r <= 2'h0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      per_r <= per_nxt;
      perb_r <= perb_nxt;
      cnt_r <= cnt_nxt;
      cc_r <= cc_nxt;
      ccb_r <= ccb_nxt;
      wg_r <= wg_nxt;
      dsl_r <= dsl_nxt;
      dead_r <= dead_nxt;
      deadb_r <= deadb_nxt;
      pat_r <= pat_nxt;
      patb_r <= patb_nxt;
      ovr_r <= ovr_nxt;
      fmask_r <= fmask_nxt;
      stat_r <= stat_nxt;
      pre_r <= pre_nxt;
      fine_r <= fine_nxt;
      port_r <= port_nxt;
      evo_r <= evo_nxt;
      t1o_r <= t1o_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;
  assign port_out = port_r;
  assign t1_out = t1o_r;
  assign evt_out = evo_r;
endmodule

// File: hdl/timer_pkg.sv
package timer_pkg;
  // Register byte offsets, one 32-bit word each
  localparam int         ADR_W   = 8;
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_PER0  = 8'h04;
  localparam logic [7:0] A_CNT0  = 8'h08;
  localparam logic [7:0] A_CC0   = 8'h0C;
  localparam logic [7:0] A_CTRL1 = 8'h1C;
  localparam logic [7:0] A_PER1  = 8'h20;
  localparam logic [7:0] A_CNT1  = 8'h24;
  localparam logic [7:0] A_CC1   = 8'h28;
  localparam logic [7:0] A_DEAD  = 8'h30;
  localparam logic [7:0] A_PAT   = 8'h34;
  localparam logic [7:0] A_OVR   = 8'h38;
  localparam logic [7:0] A_STAT  = 8'h3C;
  // Control word fields
  localparam int CT_CLK   = 0;
  localparam int CT_DN    = 4;
  localparam int CT_CAP   = 5;
  localparam int CT_SPLIT = 6;
  localparam int CT_CASC  = 7;
  localparam int CT_WEX   = 8;
  localparam int CT_HALT  = 9;
  localparam int CT_PAT   = 10;
  localparam int CT_DIST  = 11;
  localparam int CT_HR    = 12;
  localparam int CT_WG    = 14;
  localparam int CT_DEV   = 16;
  localparam int CT_DCH   = 17;
  localparam int CT_CCH   = 19;
  localparam int CT_RST   = 21;
  localparam int CT_RCH   = 22;
  localparam int OV_FM    = 8;
  // Status bits
  localparam int ST_OVF0  = 0;
  localparam int ST_OVF1  = 5;
  localparam int ST_UFHI  = 8;
  localparam int ST_FAULT = 9;
  // Encodings
  localparam logic [1:0] WG_FREQ = 2'h0;
  localparam logic [1:0] WG_SS   = 2'h1;
  localparam logic [1:0] WG_DS   = 2'h2;
  localparam logic [1:0] HR_OFF  = 2'h0;
  localparam logic [1:0] HR_8X   = 2'h2;
  localparam logic [3:0] CK_EVT  = 4'h8;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PER_RST  = 16'hFFFF;
  localparam logic [15:0] DEAD_RST = 16'h0000;
  localparam logic [7:0]  PAT_RST  = 8'h00;
endpackage

// File: testbench/power_stage_model.sv
`timescale 1ns/1ns
module power_stage_model (
  input  wire logic       clk,        // Clock
  input  wire logic       arst_n,     // Async reset
  input  wire logic       clr,        // Clear the watch flags
  input  wire logic [7:0] port_out,   // Driver inputs
  output logic      [3:0] evt_in,     // Event channels
  output logic            shoot_seen, // Both sides of pair 0 on at once
  output logic      [1:0] side_seen   // Each side of pair 0 seen on
);
  initial evt_in = 4'h0;

  // fault source
  // One-cycle event pulse; line returns low as the event system does
  task automatic fire(input int ch);
    @(posedge clk);
    evt_in[ch] <= 1'b1;
    @(posedge clk);
    evt_in[ch] <= 1'b0;
  endtask

  // shoot-through watch
  // A real bridge burns if both switches of a leg conduct together
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n || clr) begin
      shoot_seen <= 1'b0;
      side_seen  <= 2'h0;
    end else begin
      if (port_out[1:0] === 2'h3) shoot_seen <= 1'b1;
      side_seen <= side_seen | port_out[1:0];
    end
  end
endmodule

// File: testbench/timer_pair_monitor.sv
`timescale 1ns/1ns
module timer_pair_monitor (
  input wire logic                        clk,      // Clock
  input wire logic                        arst_n,   // Async reset
  input wire logic                        wb_cyc_i, // Cycle
  input wire logic                        wb_stb_i, // Strobe
  input wire logic                        wb_we_i,  // Write
  input wire logic [timer_pkg::ADR_W-1:0] wb_adr_i, // Address
  input wire logic [3:0]                  wb_sel_i, // Lanes
  input wire logic [31:0]                 wb_dat_i, // Write data
  input wire logic [31:0]                 wb_dat_o, // Read data
  input wire logic                        wb_ack_o  // Ack
);
  import timer_pkg::*;

  logic [31:0] ctrl0_r;
  logic [31:0] ctrl0_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Shadow of the control word, lane by lane, for readback
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
        {wb_adr_i[ADR_W-1:2], 2'b00} == A_CTRL0) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl0_nxt[8*b +: 8] = wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // Register the shadow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0_r <= 32'h0;
    end else begin
      ctrl0_r <= ctrl0_nxt;
    end
  end

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence

  chk_ack_next: assert property (s_req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_unmapped_zero: assert property (s_rd ##0 (wb_adr_i >= 8'h40) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (s_rd ##0 (wb_adr_i == A_PER0 || wb_adr_i == A_CNT0 ||
    wb_adr_i == A_PER1 || wb_adr_i == A_CNT1) |-> wb_dat_o[31:16] == 16'h0)
    else $error("16-bit register upper half not zero");
  chk_stat_spare: assert property (s_rd ##0 (wb_adr_i == A_STAT) |-> wb_dat_o[31:10] == 22'h0)
    else $error("status spare bits set");
  chk_ctrl1_mask: assert property (s_rd ##0 (wb_adr_i == A_CTRL1) |->
    (wb_dat_o[11:8] == 4'h0 && !wb_dat_o[6]))
    else $error("second timer shows extension or split bits");
  chk_ctrl0_back: assert property (s_rd ##0 (wb_adr_i == A_CTRL0) |->
    wb_dat_o == ctrl0_r)
    else $error("control readback differs from last write");
endmodule

bind timer_pair timer_pair_monitor timer_pair_monitor_inst (
  .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// File: testbench/timer_pair_tb_top.sv
`timescale 1ns/1ns
module timer_pair_tb_top;
  import timer_pkg::*;
  logic        clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ps_clr, shoot;
  logic [7:0]  wb_adr_i, port_out, evt_out;
  logic [3:0]  evt_in, wb_sel_i, wsel;
  logic [1:0]  t1_out, sides;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  int          n_fail, comparisons, n_ovf, a0;

  timer_pair timer_pair_inst (
    .clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_in(evt_in), .port_out(port_out),
    .t1_out(t1_out), .evt_out(evt_out)
  );
  power_stage_model power_stage_model_inst (
    .clk(clk), .arst_n(arst_n), .clr(ps_clr), .port_out(port_out),
    .evt_in(evt_in), .shoot_seen(shoot), .side_seen(sides)
  );

  // clock source: one clock stands in for the quad-rate one
  always #20 clk = ~clk;

  // Overflow pulses of timer0, compared with the cascaded count
  always @(posedge clk) if (evt_out[0] === 1'b1) n_ovf <= n_ovf + 1;

  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic bus cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int k;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= wsel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check("ack", {31'h0, wb_ack_o}, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // Watchdog, far beyond the roughly 1100 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end

  initial begin
    clk = 0; arst_n = 0; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0; ps_clr = 0;
    wb_adr_i = 8'h00; wb_dat_i = 32'h0; n_fail = 0; comparisons = 0; n_ovf = 0;
    wb_sel_i = 4'hF;
    wsel = 4'hF;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(A_PER0, v); check("per0 reset", v, {16'h0, PER_RST});
    rd(A_CTRL0, v); check("ctrl0 reset", v, CTRL_RST);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, v); check("unmapped", v, 32'h0);
    // Only the low lane is enabled, so the fault mask must stay clear
    wsel = 4'h1;
    wr(A_OVR, 32'h0000_0F5A);
    wsel = 4'hF;
    rd(A_OVR, v); check("ovr lanes", v, 32'h5A);
    $display("test reset done");
    // Event-clocked counting both ways
    wr(A_CNT0, 32'h5);
    wr(A_CTRL0, 32'(CK_EVT));
    repeat (3) power_stage_model_inst.fire(0);
    rd(A_CNT0, v); check("cnt up", v, 32'h8);
    wr(A_CTRL0, 32'(CK_EVT) | (32'h1 << CT_DN));
    repeat (3) power_stage_model_inst.fire(0);
    rd(A_CNT0, v); check("cnt down", v, 32'h5);
    // Direction event on the counting channel flips the down bit back to up
    wr(A_CTRL0, 32'(CK_EVT) | (32'h1 << CT_DN) | (32'h1 << CT_DEV));
    repeat (3) power_stage_model_inst.fire(0);
    rd(A_CNT0, v); check("cnt evt dir", v, 32'h8);
    $display("test events done");
    // Period 3 gives one overflow every 4 cycles
    wr(A_PER0, 32'h3);
    wr(A_CNT0, 32'hFFFF);
    wr(A_CTRL0, 32'h1);
    a0 = 0;
    while (evt_out[0] !== 1'b1 && a0 < 100) begin
      @(posedge clk);
      a0++;
    end
    a0 = n_ovf;
    repeat (40) @(posedge clk);
    check("period", 32'(n_ovf - a0), 32'd10);
    wr(A_CTRL0, 32'h0);
    wr(A_CNT1, 32'h0);
    wr(A_CTRL1, 32'h1 << CT_CASC);
    repeat (5) @(posedge clk);
    a0 = n_ovf;
    wr(A_CTRL0, 32'h1);
    repeat (60) @(posedge clk);
    wr(A_CTRL0, 32'h0);
    repeat (5) @(posedge clk);
    rd(A_CNT1, v); check("cascade", v, 32'(n_ovf - a0));
    $display("test period done");
    // Split halves count down; only the high half's underflow flag is checked
    wr(A_CTRL1, 32'h0);
    wr(A_STAT, 32'h3FF);
    wr(A_CTRL0, (32'h1 << CT_SPLIT) | 32'h1);
    repeat (600) @(posedge clk);
    rd(A_STAT, v); check("high underflow", {31'h0, v[ST_UFHI]}, 32'h1);
    wr(A_CTRL0, 32'h1);
    rd(A_CTRL0, v); check("normal mode", v, 32'h1);
    wr(A_CTRL1, 32'h0000_0F40);
    rd(A_CTRL1, v); check("ctrl1 mask", v, 32'h0);
    // Stopped timer one captures its count; capture mode silences its pins
    wr(A_CNT1, 32'h1234);
    wr(A_CTRL1, 32'h1 << CT_CAP);
    power_stage_model_inst.fire(0);
    rd(A_CC1, v); check("capture", v, 32'h1234);
    check("t1 capture", {30'h0, t1_out}, 32'h0);
    $display("test split done");
    // Pattern on all pins, then a fault event
    wr(A_PAT, 32'hFF);
    wr(A_OVR, 32'h1FF);
    wr(A_CTRL0, 32'h1 | (32'h1 << CT_WEX) | (32'h1 << CT_PAT));
    repeat (20) @(posedge clk);
    check("pattern", {24'h0, port_out}, 32'hFF);
    power_stage_model_inst.fire(0);
    repeat (2) @(posedge clk);
    check("fault off", {24'h0, port_out}, 32'h0);
    rd(A_STAT, v); check("fault flag", {31'h0, v[ST_FAULT]}, 32'h1);
    wr(A_STAT, 32'h1 << ST_FAULT);
    repeat (10) @(posedge clk);
    check("fault clear", {24'h0, port_out}, 32'hFF);
    $display("test pattern done");
    // Complementary pair with dead time on channel A
    wr(A_PER0, 32'hF);
    wr(A_CC0, 32'h8);
    wr(A_DEAD, 32'h0202);
    wr(A_OVR, 32'h103);
    wr(A_CTRL0, 32'h1 | (32'h1 << CT_WEX) | (32'(WG_SS) << CT_WG));
    @(posedge clk) ps_clr <= 1'b1;
    @(posedge clk) ps_clr <= 1'b0;
    repeat (200) @(posedge clk);
    check("shoot", {31'h0, shoot}, 32'h0);
    check("sides", {30'h0, sides}, 32'h3);
    $display("test dead time done");
    close_out();
  end
endmodule
